//--- sdp_map.svh
// constants for the static digital i/o port
// Behaviour
// - eight lines, each separately input or output
// - one drive style for whole port
// - push-pull drive until software changes it
// - reset makes all lines high-impedance inputs
// - sample and update only on software request
`ifndef SDP_MAP_SVH
`define SDP_MAP_SVH
`define SDP_LINES      8
`define SDP_DIR_RST    8'h00
`define SDP_OUT_RST    8'h00
`define SDP_IN_RST     8'h00
`define SDP_ODRAIN_RST 1'h0
`define SDP_OE_RST     8'h00
`define SDP_VALID_RST  1'h0
`endif

//--- sdp_pkg.sv
// types for the static digital i/o port
`include "sdp_map.svh"
package sdp_pkg;
  typedef logic [`SDP_LINES-1:0] sdp_lines_type;
endpackage

//--- sdp_static_dio_port.sv
// static digital i/o port with per-line direction and port drive style
`timescale 1ns/10ps
`include "sdp_map.svh"
module sdp_static_dio_port (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst,
  input  wire logic            i_dir_wr,
  input  wire sdp_pkg::sdp_lines_type i_dir,
  input  wire logic            i_mode_wr,
  input  wire logic            i_open_drain,
  input  wire logic            i_out_wr,
  input  wire sdp_pkg::sdp_lines_type i_out,
  input  wire logic            i_sample_req,
  input  wire sdp_pkg::sdp_lines_type i_port_lines,
  output logic                 o_open_drain,
  output sdp_pkg::sdp_lines_type o_dir,
  output sdp_pkg::sdp_lines_type o_in,
  output logic                 o_in_valid,
  output sdp_pkg::sdp_lines_type o_port_lines,
  output sdp_pkg::sdp_lines_type o_port_lines_oe
);
  import sdp_pkg::*;

  sdp_lines_type sync1;
  sdp_lines_type sync2;
  sdp_lines_type out_lvl;
  sdp_lines_type next_dir;
  sdp_lines_type next_out_lvl;
  sdp_lines_type next_in;
  sdp_lines_type next_pin;
  sdp_lines_type next_oe;
  logic          next_open_drain;
  logic          next_in_valid;

  // two-stage synchroniser on the pins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= `SDP_IN_RST;
      sync2 <= `SDP_IN_RST;
    end else begin
      sync1 <= i_port_lines;
      sync2 <= sync1;
    end
  end

  // next configuration and captured inputs
  always_comb begin
    next_dir        = i_dir_wr ? i_dir : o_dir;
    next_open_drain = i_mode_wr ? i_open_drain : o_open_drain;
    next_out_lvl    = i_out_wr ? i_out : out_lvl;
    next_in         = i_sample_req ? sync2 : o_in;
    next_in_valid   = i_sample_req;
  end

  // per-line pin drive from direction, level and style
  genvar g;
  generate
    for (g = 0; g < `SDP_LINES; g++) begin : g_line
      always_comb begin
        if (next_open_drain) begin
          next_pin[g] = 1'b0;
          next_oe[g]  = next_dir[g] & ~next_out_lvl[g];
        end else begin
          next_pin[g] = next_out_lvl[g];
          next_oe[g]  = next_dir[g];
        end
      end
    end
  endgenerate

  // register state and pins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dir           <= `SDP_DIR_RST;
      o_open_drain    <= `SDP_ODRAIN_RST;
      out_lvl         <= `SDP_OUT_RST;
      o_in            <= `SDP_IN_RST;
      o_in_valid      <= `SDP_VALID_RST;
      o_port_lines    <= `SDP_OUT_RST;
      o_port_lines_oe <= `SDP_OE_RST;
    end else begin
      o_dir           <= next_dir;
      o_open_drain    <= next_open_drain;
      out_lvl         <= next_out_lvl;
      o_in            <= next_in;
      o_in_valid      <= next_in_valid;
      o_port_lines    <= next_pin;
      o_port_lines_oe <= next_oe;
    end
  end

  // drive only lines set as outputs
  a_oe_needs_dir: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_port_lines_oe & ~o_dir) == 8'h00)
    else $error("output enable on an input line");
  // open drain never drives high
  a_od_no_high: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_open_drain |-> ((o_port_lines & o_port_lines_oe) == 8'h00))
    else $error("open-drain line driven high");
  // push-pull enables every output line
  a_pp_enables: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !o_open_drain |-> (o_port_lines_oe == o_dir))
    else $error("push-pull enable mismatch");
  // mode write lands next cycle for whole port
  a_mode_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_mode_wr |=> (o_open_drain == $past(i_open_drain)))
    else $error("drive style not updated");
  // input held without request
  a_in_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_sample_req |=> $stable(o_in))
    else $error("input changed without request");
  // pin output enables follow only software writes
  a_pin_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!i_out_wr && !i_dir_wr && !i_mode_wr) |=> $stable(o_port_lines_oe))
    else $error("pin drive changed without request");
  // reset leaves all lines released
  a_reset_hiz: assert property (@(posedge i_core_clk)
    i_rst |=> (o_port_lines_oe == 8'h00) || i_rst)
    else $error("line driven after reset");
  // sample takes synchronised pin value
  a_sample_val: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_sample_req |=> (o_in == $past(sync2)) && o_in_valid)
    else $error("sample value wrong");
endmodule

//--- sdp_ext_circuit.sv
// external circuit model: pull-up on every line, source on input lines
`timescale 1ns/10ps
module sdp_ext_circuit (
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_lvl,
  input  wire logic [7:0] i_src,
  input  wire logic [7:0] i_src_en,
  output logic      [7:0] o_wire
);
  // a driven line wins, then the source, else the pull-up holds it high
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      o_wire[n] = i_oe[n] ? i_lvl[n] : (i_src_en[n] ? i_src[n] : 1'b1);
    end
  end
endmodule

//--- tb_top.sv
// self-checking bench for the static digital i/o port
`timescale 1ns/10ps
module tb_top;
  import sdp_pkg::*;
  logic          i_core_clk = 0, i_rst = 1, i_dir_wr = 0, i_mode_wr = 0;
  logic          i_open_drain = 0, i_out_wr = 0, i_sample_req = 0, od = 0;
  logic          o_open_drain, o_in_valid;
  sdp_lines_type i_dir = '0, i_out = '0, src = '0, i_port_lines;
  sdp_lines_type o_dir, o_in, o_port_lines, o_port_lines_oe;
  logic [32:0]   got;
  logic [32:0]   exp_q[$];
  int            err_count = 0, n_tests = 0, cycles = 0, seed = 67;
  assign got = {o_open_drain, o_dir, o_in, o_port_lines_oe,
                o_port_lines & o_port_lines_oe};
  sdp_static_dio_port DUT (.i_core_clk, .i_rst, .i_dir_wr, .i_dir,
    .i_mode_wr, .i_open_drain, .i_out_wr, .i_out, .i_sample_req,
    .i_port_lines, .o_open_drain, .o_dir, .o_in, .o_in_valid,
    .o_port_lines, .o_port_lines_oe);
  sdp_ext_circuit ext (.i_oe(o_port_lines_oe), .i_lvl(o_port_lines),
    .i_src(src), .i_src_en(~o_dir), .o_wire(i_port_lines));
  always #4 i_core_clk = ~i_core_clk;
  task automatic err(input string m);
    err_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic end_of_test;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watcher: each sample result is matched to the oldest expectation
  always @(negedge i_core_clk) if (o_in_valid === 1'b1) begin
    n_tests++;
    if (exp_q.size() == 0) err("sample without request");
    else if (got !== exp_q.pop_front()) err("port mismatch");
  end
  // cycle ceiling cuts a hang short
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err("timeout");
      end_of_test();
    end
  end
  // random writes of direction, levels and style, then a sample request
  initial begin
    repeat (16) @(posedge i_core_clk);
    n_tests++;
    #1 if ({o_port_lines_oe, o_dir, o_open_drain} !== 17'h0) err("reset");
    i_rst = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge i_core_clk) #1;
      i_dir = $random(seed);
      i_out = $random(seed);
      src = $random(seed);
      {i_dir_wr, i_out_wr, i_mode_wr} = {2'b11, k > 0};
      i_open_drain = (k > 0) && $random(seed) % 2;
      od = i_mode_wr ? i_open_drain : od;
      exp_q.push_back({od, i_dir, (i_dir & i_out) | (~i_dir & src),
        od ? i_dir & ~i_out : i_dir, od ? 8'h00 : i_dir & i_out});
      @(posedge i_core_clk) #1;
      {i_dir_wr, i_out_wr, i_mode_wr} = 3'h0;
      repeat (3) @(posedge i_core_clk);
      #1 i_sample_req = 1;
      @(posedge i_core_clk) #1 i_sample_req = 0;
    end
    repeat (4) @(posedge i_core_clk);
    n_tests++;
    if (exp_q.size() != 0) err("missing sample result");
    // mid-run reset must release every driven line
    @(posedge i_core_clk) #1 i_rst = 1;
    @(posedge i_core_clk) #1;
    n_tests++;
    if ({o_port_lines_oe, o_dir, o_open_drain} !== 17'h0) err("mid reset");
    i_rst = 0;
    repeat (2) @(posedge i_core_clk);
    end_of_test();
  end
endmodule
